// ### rtl/bam_pkg.sv
// Purpose: shared types and constants for the byte alu and multiplier
// Assumes: one core clock, decoder drives one operation request at a time
// Notes: flag vector order is {s, v, n, z, c, h}
package bam_pkg;
  localparam int BAM_W = 8;
  localparam int BAM_CYC_SINGLE = 1;
  localparam int BAM_CYC_DOUBLE = 2;
  localparam logic [7:0] BAM_ALL_ONES = 8'hFF;
  localparam logic [5:0] BAM_FLAGS_RST = 6'h00;

  typedef enum logic [4:0] {
    BAM_OP_SUM      = 5'h00,
    BAM_OP_DIFF     = 5'h01,
    BAM_OP_AND      = 5'h02,
    BAM_OP_OR       = 5'h03,
    BAM_OP_XOR      = 5'h04,
    BAM_OP_CLRMASK  = 5'h05,
    BAM_OP_TEST     = 5'h06,
    BAM_OP_WSUM     = 5'h07,
    BAM_OP_WDIFF    = 5'h08,
    BAM_OP_MULU     = 5'h09,
    BAM_OP_PRODUCT_SIGNED     = 5'h0A,
    BAM_OP_PRODUCT_SIGNED_BY_UNSIGNED    = 5'h0B,
    BAM_OP_FMULU    = 5'h0C
  } bam_op_e;

  typedef struct packed {
    logic s;
    logic v;
    logic n;
    logic z;
    logic c;
    logic h;
  } bam_flags_s;

  // one request from the decoder
  typedef struct packed {
    bam_op_e op;
    logic use_carry;
    logic use_imm;
    logic [7:0] dst;
    logic [7:0] dst_hi;
    logic [7:0] src;
    logic [7:0] imm;
  } bam_req_s;

  // one result toward the register file
  typedef struct packed {
    logic wr_dst;
    logic wr_hi;
    logic wr_pair;
    logic [7:0] lo;
    logic [7:0] hi;
  } bam_res_s;
endpackage

// ### rtl/bam_mul.sv
// Purpose: 8x8 multiplier with signed, mixed and fractional forms
// Assumes: operands stable while the request is held
// Notes: purely combinational; the caller registers the product
`timescale 1ns/1ps
module bam_mul (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic a_signed,
  input wire logic b_signed,
  input wire logic frac,
  output logic [15:0] prod,
  output logic carry
);
  logic signed [17:0] full;
  // sign extend each operand by its own mode, then one signed product
  always_comb begin
    full = $signed({a_signed & a[7], a}) * $signed({b_signed & b[7], b});
    carry = full[15];
    prod = frac ? {full[14:0], 1'b0} : full[15:0];
  end
endmodule

// ### rtl/bam_alu.sv
// Purpose: arithmetic, logic and multiply datapath of an 8-bit core
// Assumes: decoder holds req stable from start until done
// Notes: single ops finish at the next edge, word and multiply ops at the second
//
// Operation
// RL1 - register add, optional carry, ZCNVH, 1 cycle
// RL2 - word immediate add, ZCNVS, 2 cycles
// RL3 - register subtract, optional borrow, ZCNVH, 1 cycle
// RL4 - immediate subtract, optional borrow, ZCNVH, 1 cycle
// RL5 - word immediate subtract, ZCNVS, 2 cycles
// RL6 - conjunction reg or immediate, ZNV, 1 cycle
// RL7 - disjunction reg or immediate, ZNV, 1 cycle
// RL8 - exclusive disjunction of registers, ZNV, 1 cycle
// RL9 - clear or set bits by mask, ZNV
// RL10 - zero sign check, value kept, ZNV
// RL11 - integer products into product pair, ZC, 2 cycles
// RL12 - fractional product shifted left, ZC, 2 cycles
// RL13 - unaffected flags keep their values
`timescale 1ns/1ps
module bam_alu (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire bam_pkg::bam_req_s req,
  output logic busy,
  output logic done,
  output bam_pkg::bam_res_s res,
  output bam_pkg::bam_flags_s flags
);
  import bam_pkg::*;

  typedef enum logic [1:0] {
    BAM_ST_IDLE = 2'b01,
    BAM_ST_SECOND = 2'b10
  } bam_state_e;

  bam_state_e state_r;
  bam_flags_s flags_r, flags_nxt;
  bam_res_s res_r, res_nxt;
  logic done_r;
  logic [7:0] opb, r8;
  logic [8:0] sum9;
  logic [4:0] half5;
  logic [15:0] w16, prod;
  logic [16:0] w17;
  logic mcarry, two_cycle, cin;

  function automatic logic is_double(input bam_op_e op);
    is_double = (op == BAM_OP_WSUM) || (op == BAM_OP_WDIFF) || (op == BAM_OP_MULU) ||
                (op == BAM_OP_PRODUCT_SIGNED) || (op == BAM_OP_PRODUCT_SIGNED_BY_UNSIGNED) || (op == BAM_OP_FMULU);
  endfunction

  assign two_cycle = is_double(req.op);
  assign opb = req.use_imm ? req.imm : req.src;
  assign cin = req.use_carry & flags_r.c;

  bam_mul u_mul (
    .a(req.dst),
    .b(req.src),
    .a_signed((req.op == BAM_OP_PRODUCT_SIGNED) || (req.op == BAM_OP_PRODUCT_SIGNED_BY_UNSIGNED)),
    .b_signed(req.op == BAM_OP_PRODUCT_SIGNED),
    .frac(req.op == BAM_OP_FMULU),
    .prod(prod),
    .carry(mcarry)
  );

  // result and flag computation, flags default to old values
  always_comb begin
    // RL13 unaffected flags hold
    flags_nxt = flags_r;
    res_nxt = '0;
    r8 = 8'h00;
    sum9 = 9'h000;
    half5 = 5'h00;
    w16 = 16'h0000;
    w17 = 17'h00000;
    unique case (req.op)
      // RL1 add with carry
      BAM_OP_SUM: begin
        sum9 = {1'b0, req.dst} + {1'b0, opb} + {8'h00, cin};
        half5 = {1'b0, req.dst[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
        r8 = sum9[7:0];
        flags_nxt.c = sum9[8];
        flags_nxt.h = half5[4];
        flags_nxt.v = (req.dst[7] == opb[7]) && (r8[7] != req.dst[7]);
      end
      // RL3 RL4 subtract with borrow
      BAM_OP_DIFF: begin
        sum9 = {1'b0, req.dst} - {1'b0, opb} - {8'h00, cin};
        half5 = {1'b0, req.dst[3:0]} - {1'b0, opb[3:0]} - {4'h0, cin};
        r8 = sum9[7:0];
        flags_nxt.c = sum9[8];
        flags_nxt.h = half5[4];
        flags_nxt.v = (req.dst[7] != opb[7]) && (r8[7] != req.dst[7]);
      end
      // RL6 RL10 conjunction and zero sign check
      BAM_OP_AND, BAM_OP_TEST: r8 = req.dst & ((req.op == BAM_OP_TEST) ? req.dst : opb);
      // RL7 RL9 disjunction and set mask
      BAM_OP_OR: r8 = req.dst | opb;
      // RL8 exclusive disjunction
      BAM_OP_XOR: r8 = req.dst ^ opb;
      // RL9 clear mask
      BAM_OP_CLRMASK: r8 = req.dst & (BAM_ALL_ONES - req.imm);
      // RL2 RL5 word immediate
      BAM_OP_WSUM, BAM_OP_WDIFF: begin
        if (req.op == BAM_OP_WSUM) begin
          w17 = {1'b0, req.dst_hi, req.dst} + {9'h000, req.imm};
        end else begin
          w17 = {1'b0, req.dst_hi, req.dst} - {9'h000, req.imm};
        end
        w16 = w17[15:0];
        flags_nxt.c = w17[16];
        flags_nxt.v = (req.op == BAM_OP_WSUM) ? (~req.dst_hi[7] & w16[15])
                                              : (req.dst_hi[7] & ~w16[15]);
        flags_nxt.n = w16[15];
        flags_nxt.z = (w16 == 16'h0000);
        flags_nxt.s = flags_nxt.n ^ flags_nxt.v;
      end
      // RL11 RL12 products
      default: begin
        w16 = prod;
        flags_nxt.c = mcarry;
        flags_nxt.z = (prod == 16'h0000);
      end
    endcase
    if (!two_cycle) begin
      // RL6 logic ops clear v
      if (req.op != BAM_OP_SUM && req.op != BAM_OP_DIFF) begin
        flags_nxt.v = 1'b0;
      end
      flags_nxt.n = r8[7];
      flags_nxt.z = (r8 == 8'h00);
      res_nxt.wr_dst = (req.op != BAM_OP_TEST);
      res_nxt.lo = r8;
    end else begin
      res_nxt.lo = w16[7:0];
      res_nxt.hi = w16[15:8];
      res_nxt.wr_hi = (req.op == BAM_OP_WSUM) || (req.op == BAM_OP_WDIFF);
      res_nxt.wr_dst = res_nxt.wr_hi;
      res_nxt.wr_pair = !res_nxt.wr_hi;
    end
  end

  // sequencer, two-cycle ops spend one extra state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= BAM_ST_IDLE;
    end else begin
      unique case (state_r)
        BAM_ST_IDLE: if (start && two_cycle) state_r <= BAM_ST_SECOND;
        BAM_ST_SECOND: state_r <= BAM_ST_IDLE;
      endcase
    end
  end

  // results and flags commit together on the final cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= BAM_FLAGS_RST;
      res_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      res_r.wr_dst <= 1'b0;
      res_r.wr_hi <= 1'b0;
      res_r.wr_pair <= 1'b0;
      if ((state_r == BAM_ST_IDLE && start && !two_cycle) || state_r == BAM_ST_SECOND) begin
        flags_r <= flags_nxt;
        res_r <= res_nxt;
        done_r <= 1'b1;
      end
    end
  end

  assign busy = (state_r == BAM_ST_SECOND);
  assign done = done_r;
  assign res = res_r;
  assign flags = flags_r;

  property p_single_one;
    @(posedge clk) disable iff (!rstn) (start && !busy && !two_cycle) |=> done;
  endproperty
  a_single_one: assert property (p_single_one) else $error("single op late"); // RL1

  property p_double_two;
    @(posedge clk) disable iff (!rstn) (start && !busy && two_cycle) |=> !done ##1 done;
  endproperty
  a_double_two: assert property (p_double_two) else $error("double op timing"); // RL11

  property p_mul_pair;
    @(posedge clk) disable iff (!rstn)
      (start && !busy && req.op == BAM_OP_MULU) |=> ##1 (res.wr_pair &&
        {res.hi, res.lo} == $past(req.dst, 2) * $past(req.src, 2));
  endproperty
  a_mul_pair: assert property (p_mul_pair) else $error("product wrong"); // RL11

  property p_add;
    @(posedge clk) disable iff (!rstn)
      (start && !busy && req.op == BAM_OP_SUM && !req.use_carry) |=>
        res.lo == 8'($past(req.dst) + $past(opb));
  endproperty
  a_add: assert property (p_add) else $error("sum wrong"); // RL1

  property p_sub_c;
    @(posedge clk) disable iff (!rstn)
      (start && !busy && req.op == BAM_OP_DIFF && !req.use_carry) |=>
        flags.c == ($past(req.dst) < $past(opb));
  endproperty
  a_sub_c: assert property (p_sub_c) else $error("borrow wrong"); // RL3

  property p_logic_v;
    @(posedge clk) disable iff (!rstn)
      (start && !busy && req.op inside {BAM_OP_AND, BAM_OP_OR, BAM_OP_XOR}) |=>
        !flags.v && flags.c == $past(flags.c) && flags.h == $past(flags.h);
  endproperty
  a_logic_v: assert property (p_logic_v) else $error("logic flags wrong"); // RL6

  property p_test_keep;
    @(posedge clk) disable iff (!rstn)
      (start && !busy && req.op == BAM_OP_TEST) |=>
        !res.wr_dst && flags.z == ($past(req.dst) == 8'h00);
  endproperty
  a_test_keep: assert property (p_test_keep) else $error("test wrote"); // RL10

  property p_mul_keep;
    @(posedge clk) disable iff (!rstn)
      (start && !busy && req.op == BAM_OP_MULU) |=> ##1 flags.n == $past(flags.n, 2);
  endproperty
  a_mul_keep: assert property (p_mul_keep) else $error("mul touched n"); // RL13

  c_single: cover property (@(posedge clk) disable iff (!rstn) start && !two_cycle ##1 done);
  c_word: cover property (@(posedge clk) disable iff (!rstn)
    start && req.op == BAM_OP_WSUM ##2 done);
  c_frac: cover property (@(posedge clk) disable iff (!rstn)
    start && req.op == BAM_OP_FMULU ##2 done);
endmodule

// ### sim/tb_top.sv
// Purpose: self-checking bench for the byte alu and multiplier
// Assumes: one request at a time, req held until done
// Notes: driver queues expected results, a monitor compares them when done pulses
`timescale 1ns/1ps
module tb_top;
  import bam_pkg::*;
  typedef struct packed {
    bam_res_s res;
    bam_flags_s fl;
    logic full;
    logic [1:0] lat;
  } bam_exp_s;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic start = 1'h0;
  bam_req_s req = '0;
  logic busy;
  logic done;
  bam_res_s res;
  bam_flags_s flags;
  bam_flags_s mf = '0;
  bam_exp_s q[$];
  bam_exp_s ex;
  bam_res_s got;
  bam_op_e o;
  logic [31:0] v;
  int errors = 0;
  int total_checks = 0;
  int seed = 47850;

  bam_alu dut_u (.clk(clk), .rstn(rstn), .start(start), .req(req), .busy(busy),
    .done(done), .res(res), .flags(flags));

  // 100 ns core clock
  always #50 clk = ~clk;

  task automatic check(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // reference model; flags not touched by an op keep the old value
  function automatic bam_exp_s model(input bam_req_s r, input bam_flags_s f);
    bam_exp_s e;
    logic [7:0] b;
    logic [8:0] t;
    logic [4:0] h;
    logic [16:0] w;
    logic [15:0] p;
    logic ci;
    e = '0;
    e.fl = f;
    e.lat = 2'h1;
    b = r.use_imm ? r.imm : r.src;
    ci = r.use_carry & f.c;
    case (r.op)
      BAM_OP_SUM, BAM_OP_DIFF: begin
        if (r.op == BAM_OP_SUM) begin
          t = {1'h0, r.dst} + {1'h0, b} + ci;
          h = {1'h0, r.dst[3:0]} + {1'h0, b[3:0]} + ci;
          e.fl.v = (r.dst[7] == b[7]) && (t[7] != r.dst[7]);
        end else begin
          t = {1'h0, r.dst} - {1'h0, b} - ci;
          h = {1'h0, r.dst[3:0]} - {1'h0, b[3:0]} - ci;
          e.fl.v = (r.dst[7] != b[7]) && (t[7] != r.dst[7]);
        end
        e.res.lo = t[7:0];
        e.fl.c = t[8];
        e.fl.h = h[4];
      end
      BAM_OP_AND: e.res.lo = r.dst & b;
      BAM_OP_OR: e.res.lo = r.dst | b;
      BAM_OP_XOR: e.res.lo = r.dst ^ b;
      BAM_OP_CLRMASK: e.res.lo = r.dst & (BAM_ALL_ONES - r.imm);
      BAM_OP_TEST: e.res.lo = r.dst;
      BAM_OP_WSUM, BAM_OP_WDIFF: begin
        if (r.op == BAM_OP_WSUM) begin
          w = {1'h0, r.dst_hi, r.dst} + {9'h000, r.imm};
          e.fl.v = !r.dst_hi[7] && w[15];
        end else begin
          w = {1'h0, r.dst_hi, r.dst} - {9'h000, r.imm};
          e.fl.v = r.dst_hi[7] && !w[15];
        end
        {e.res.hi, e.res.lo} = w[15:0];
        e.fl.c = w[16];
        e.fl.n = w[15];
        e.fl.s = w[15] ^ e.fl.v;
        e.fl.z = (w[15:0] == 16'h0000);
        e.res.wr_hi = 1'h1;
      end
      default: begin
        case (r.op)
          BAM_OP_PRODUCT_SIGNED: p = $signed(r.dst) * $signed(r.src);
          BAM_OP_PRODUCT_SIGNED_BY_UNSIGNED: p = $signed(r.dst) * $signed({1'h0, r.src});
          default: p = r.dst * r.src;
        endcase
        e.fl.c = p[15];
        if (r.op == BAM_OP_FMULU) p = p << 1;
        {e.res.hi, e.res.lo} = p;
        e.fl.z = (p == 16'h0000);
        e.res.wr_pair = 1'h1;
      end
    endcase
    e.full = e.res.wr_hi | e.res.wr_pair;
    e.res.wr_dst = !e.res.wr_pair && r.op != BAM_OP_TEST;
    if (e.full) e.lat = 2'h2;
    if (r.op < BAM_OP_WSUM) begin
      e.fl.n = e.res.lo[7];
      e.fl.z = (e.res.lo == 8'h00);
      if (r.op > BAM_OP_DIFF) e.fl.v = 1'h0;
    end
    return e;
  endfunction

  // hold keeps start up into the busy cycle, where it must be ignored
  task automatic op(input bam_op_e oo, input logic uc, input logic ui, input logic [7:0] d,
      input logic [7:0] dh, input logic [7:0] s, input logic [7:0] k, input logic hold);
    bam_req_s r;
    bam_exp_s e;
    int n;
    r = '{oo, uc, ui, d, dh, s, k};
    e = model(r, mf);
    mf = e.fl;
    q.push_back(e);
    start <= 1'h1;
    req <= r;
    @(posedge clk);
    start <= hold;
    n = 0;
    // drop a held start only once, so a following call never drives it twice
    do begin
      @(posedge clk);
      if (hold && n == 0) start <= 1'h0;
      n++;
      check(32'(busy), 32'(n < e.lat)); // busy only in second cycle
    end while (done !== 1'h1 && n < 8);
    check(32'(n), 32'(e.lat)); // cycle count
    if (done !== 1'h1) final_report();
  endtask

  // compare oldest note with each result; hi only where a word or a pair is written
  always @(posedge clk) begin
    if (done === 1'h1) begin
      if (q.size() > 0) ex = q.pop_front();
      else ex = '1;
      got = res;
      if (!ex.full) got.hi = ex.res.hi;
      check(got, ex.res); // result
      check(flags, ex.fl); // flags
    end else begin
      check({res.wr_dst, res.wr_hi, res.wr_pair}, 3'h0); // strobes pulse once
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    check({done, busy, flags}, 8'h00); // idle outputs in reset
    @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    op(BAM_OP_SUM, 1'h0, 1'h0, 8'h0F, 8'h00, 8'h01, 8'h00, 1'h0); // half carry
    op(BAM_OP_SUM, 1'h0, 1'h0, 8'h7F, 8'h00, 8'h01, 8'h00, 1'h0); // overflow
    op(BAM_OP_SUM, 1'h0, 1'h0, 8'hFF, 8'h00, 8'h01, 8'h00, 1'h0); // carry zero
    op(BAM_OP_SUM, 1'h1, 1'h0, 8'h10, 8'h00, 8'h20, 8'h00, 1'h0); // carry in
    op(BAM_OP_DIFF, 1'h0, 1'h1, 8'h00, 8'h00, 8'h00, 8'h01, 1'h0); // borrow
    op(BAM_OP_DIFF, 1'h1, 1'h1, 8'h80, 8'h00, 8'h00, 8'h00, 1'h0); // borrow in
    op(BAM_OP_CLRMASK, 1'h0, 1'h1, 8'hF0, 8'h00, 8'h00, 8'h30, 1'h0); // clear mask
    op(BAM_OP_OR, 1'h0, 1'h1, 8'h01, 8'h00, 8'h00, 8'h80, 1'h0); // set mask
    op(BAM_OP_TEST, 1'h0, 1'h0, 8'h00, 8'h00, 8'h00, 8'h00, 1'h0); // zero
    op(BAM_OP_WSUM, 1'h0, 1'h0, 8'hFF, 8'hFF, 8'h00, 8'h01, 1'h0); // wrap
    op(BAM_OP_WSUM, 1'h0, 1'h0, 8'hFF, 8'h7F, 8'h00, 8'h01, 1'h1); // overflow
    op(BAM_OP_WDIFF, 1'h0, 1'h0, 8'h00, 8'h00, 8'h00, 8'h01, 1'h0); // borrow
    op(BAM_OP_WDIFF, 1'h0, 1'h0, 8'h00, 8'h80, 8'h00, 8'h01, 1'h0); // overflow
    op(BAM_OP_PRODUCT_SIGNED, 1'h0, 1'h0, 8'h80, 8'h00, 8'h80, 8'h00, 1'h0); // signed
    op(BAM_OP_PRODUCT_SIGNED_BY_UNSIGNED, 1'h0, 1'h0, 8'hFF, 8'h00, 8'h02, 8'h00, 1'h1); // mixed
    op(BAM_OP_MULU, 1'h0, 1'h0, 8'h00, 8'h00, 8'h5A, 8'h00, 1'h0); // zero
    op(BAM_OP_FMULU, 1'h0, 1'h0, 8'hFF, 8'h00, 8'hFF, 8'h00, 1'h0); // shift
    // second reset in mid-run clears flags and outputs
    rstn <= 1'h0;
    repeat (2) @(posedge clk);
    check({done, busy, flags}, 8'h00); // flags cleared by reset
    mf = '0;
    rstn <= 1'h1;
    @(posedge clk);
    repeat (300) begin
      o = bam_op_e'(5'(($random(seed) & 32'h7FFF) % 13));
      v = $random(seed);
      op(o, v[0] & (o <= BAM_OP_DIFF), v[1] & (o <= BAM_OP_OR), v[15:8], v[23:16],
        v[31:24], v[7:0], v[2] & (o >= BAM_OP_WSUM)); // mixes
    end
    repeat (3) @(posedge clk);
    check(32'(q.size()), 32'h0); // every note answered
    final_report();
  end
endmodule
